// *** design/fcs_pkg.sv ***
// Purpose: shared constants and types of the flash command sequencer
// Assumes: 100 MHz system clock, 16-bit CPU address, 8-bit data
// Notes:   timing counts are derived from the printed times and the clock period
package fcs_pkg;

  // clock and operation times
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned PROG_TIME_US       = 40;
  localparam int unsigned PROT_TIME_US       = 40;
  localparam int unsigned SECT_ERASE_TIME_MS = 30;
  localparam int unsigned CHIP_ERASE_TIME_MS = 30;
  // all times round down to whole cycles
  localparam int unsigned PROG_CYCLES        = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PROT_CYCLES        = (PROT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned SECT_ERASE_CYCLES  = (SECT_ERASE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned CHIP_ERASE_CYCLES  = (CHIP_ERASE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W              = 22;

  // command cycle addresses
  localparam logic [11:0] CMD_ADDR_A     = 12'h555;
  localparam logic [11:0] CMD_ADDR_B     = 12'haaa;
  localparam logic [15:0] PROT_ADDR      = 16'hff7f;
  localparam logic [15:0] ID_VENDOR_ADDR = 16'hf000;
  localparam logic [15:0] ID_MACRO_ADDR  = 16'hf001;
  localparam logic [15:0] ID_SIZE_ADDR   = 16'hf002;

  // command cycle data
  localparam logic [7:0] D_UNLOCK1   = 8'haa;
  localparam logic [7:0] D_UNLOCK2   = 8'h55;
  localparam logic [7:0] D_PROG      = 8'ha0;
  localparam logic [7:0] D_ERASE     = 8'h80;
  localparam logic [7:0] D_SECT      = 8'h30;
  localparam logic [7:0] D_CHIP      = 8'h10;
  localparam logic [7:0] D_ID_ENTRY  = 8'h90;
  localparam logic [7:0] D_ID_EXIT   = 8'hf0;
  localparam logic [7:0] D_PROT      = 8'ha5;
  localparam logic [7:0] D_PROT_CONF = 8'h00;
  localparam logic [7:0] D_PROT_OFF  = 8'hff;
  localparam logic [7:0] D_BLOCKED   = 8'h00;

  // size codes read at the size address
  localparam logic [7:0] SIZE_60K = 8'h0e;
  localparam logic [7:0] SIZE_48K = 8'h0b;
  localparam logic [7:0] SIZE_32K = 8'h07;
  localparam logic [7:0] SIZE_24K = 8'h05;
  localparam logic [7:0] SIZE_16K = 8'h03;
  localparam logic [7:0] SIZE_8K  = 8'h01;

  // command-enable field values
  localparam logic [3:0] CMD_EN_ON  = 4'h3;
  localparam logic [3:0] CMD_EN_RST = 4'hc;

  localparam int unsigned TOGGLE_BIT = 6;
  localparam int unsigned SECT_MSB   = 15;
  localparam int unsigned SECT_LSB   = 12;

  typedef enum logic [1:0] {
    MODE_MCU      = 2'b00,
    MODE_SERIAL   = 2'b01,
    MODE_PARALLEL = 2'b10
  } fcs_mode_t;

  typedef enum logic [3:0] {
    S_IDLE      = 4'b0000,
    S_UNL1      = 4'b0001,
    S_UNL2      = 4'b0010,
    S_PROG_DATA = 4'b0011,
    S_ERS3      = 4'b0100,
    S_ERS4      = 4'b0101,
    S_ERS5      = 4'b0110,
    S_PROT_CONF = 4'b0111,
    S_BUSY      = 4'b1000
  } fcs_state_t;

endpackage

// *** design/fcs_tmr_if.sv ***
// Purpose: carries an operation timer request and its completion
// Assumes: single clock domain
// Notes:   done is combinational in the timer and read in the same cycle
interface fcs_tmr_if;
  import fcs_pkg::*;
  logic             start;
  logic [TMR_W-1:0] cycles;
  logic             done;
  modport ctl (output start, output cycles, input done);
  modport tmr (input start, input cycles, output done);
endinterface

// *** design/fcs_timer.sv ***
// Purpose: counts the duration of a program, erase or protect operation
// Assumes: start is a one-cycle pulse, cycles is at least one
// Notes:   done is high in the last cycle of the counted duration
module fcs_timer
  import fcs_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  fcs_tmr_if.tmr    tmr
);

  logic [TMR_W-1:0] cnt_q;

  // load on start, count down to zero
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_q <= '0;
    end
    else if (i_ce)
    begin
      if (tmr.start)
      begin
        cnt_q <= tmr.cycles;
      end
      else if (cnt_q != '0)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // last counted cycle
  assign tmr.done = (cnt_q == {{(TMR_W-1){1'b0}}, 1'b1});

endmodule

// *** design/fcs_top.sv ***
// Purpose: decodes CPU write-cycle command sequences for the embedded flash array
// Assumes: bus strobes come from same-clock logic; boot mode comes from pins
// Notes:   the array performs the work; this block starts it and times it out
module fcs_top
  import fcs_pkg::*;
#(
  parameter int unsigned SECT_CYC = SECT_ERASE_CYCLES,
  parameter int unsigned CHIP_CYC = CHIP_ERASE_CYCLES,
  parameter logic [7:0]  VENDOR_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0]  MACRO_CODE  = 8'h3c, // arbitrary value
  parameter logic [7:0]  SIZE_CODE   = SIZE_16K
)
(
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_NRST,
  input  wire logic       I_CE,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  input  wire logic [15:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_CMD_EN_WR,
  input  wire logic [3:0] I_CMD_EN_VAL,
  input  wire logic [1:0] I_BOOT_MODE,
  input  wire logic [7:0] I_ARR_RDATA,
  input  wire logic       I_ARR_PROT,
  output logic      [7:0] O_RDATA,
  output logic            O_RVALID,
  output logic            O_BUSY,
  output logic            O_ID_MODE,
  output logic      [3:0] O_CMD_EN,
  output logic            O_ARR_PROG,
  output logic            O_ARR_SECT_ERASE,
  output logic            O_ARR_CHIP_ERASE,
  output logic            O_ARR_PROT_SET,
  output logic     [15:0] O_ARR_ADDR,
  output logic      [7:0] O_ARR_WDATA,
  output logic      [3:0] O_ERASE_SECTOR_ADDRESS,
  output logic            O_PAR_RD_BLOCK,
  output logic            O_SER_CMD_BLOCK
);

  fcs_state_t st_q;
  fcs_state_t st_d;
  logic [1:0] mode_meta_q;
  logic [1:0] mode_q;
  logic [3:0] cmd_en_q;
  logic       id_q;
  logic       toggle_q;
  logic       wr_ok;
  logic       hit_a;
  logic       hit_b;
  logic       start_prog;
  logic       start_sect;
  logic       start_chip;
  logic       start_prot;
  logic       id_set;
  logic       id_clr;
  logic       par_mode;
  logic [7:0] rd_val;

  fcs_tmr_if tmr_if ();

  fcs_timer u_timer (
    .i_clk  (I_SYS_CLK),
    .i_nrst (I_NRST),
    .i_ce   (I_CE),
    .tmr    (tmr_if.tmr)
  );

  // boot mode pins pass two flops
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      mode_meta_q <= 2'h0;
      mode_q      <= 2'h0;
    end
    else if (I_CE)
    begin
      mode_meta_q <= I_BOOT_MODE;
      mode_q      <= mode_meta_q;
    end
  end

  assign par_mode = (mode_q == MODE_PARALLEL);

  // command-enable field, disabled after reset
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      cmd_en_q <= CMD_EN_RST;
    end
    else if (I_CE && I_CMD_EN_WR)
    begin
      cmd_en_q <= I_CMD_EN_VAL;
    end
  end

  // a write counts only when enabled and idle of operations
  assign wr_ok = I_WR && (cmd_en_q == CMD_EN_ON) && (st_q != S_BUSY);
  assign hit_a = (I_ADDR[11:0] == CMD_ADDR_A);
  assign hit_b = (I_ADDR[11:0] == CMD_ADDR_B);

  // sequence decoder
  always_comb
  begin
    st_d       = st_q;
    start_prog = 1'b0;
    start_sect = 1'b0;
    start_chip = 1'b0;
    start_prot = 1'b0;
    id_set     = 1'b0;
    id_clr     = 1'b0;
    if (st_q == S_BUSY)
    begin
      if (tmr_if.done)
      begin
        st_d = S_IDLE;
      end
    end
    else if (wr_ok)
    begin
      st_d = S_IDLE;
      // single-write exit at any address, except as program data
      if (I_WDATA == D_ID_EXIT && st_q != S_PROG_DATA)
      begin
        id_clr = 1'b1;
      end
      case (st_q)
        S_IDLE:
        begin
          if (hit_a && I_WDATA == D_UNLOCK1)
          begin
            st_d = S_UNL1;
          end
        end
        S_UNL1:
        begin
          if (hit_b && I_WDATA == D_UNLOCK2)
          begin
            st_d = S_UNL2;
          end
        end
        S_UNL2:
        begin
          if (hit_a)
          begin
            case (I_WDATA)
              D_PROG:     st_d = S_PROG_DATA;
              D_ERASE:    st_d = S_ERS3;
              D_PROT:     st_d = S_PROT_CONF;
              D_ID_ENTRY: id_set = 1'b1;
              default:    st_d = S_IDLE;
            endcase
          end
        end
        S_PROG_DATA:
        begin
          start_prog = 1'b1;
          st_d       = S_BUSY;
        end
        S_ERS3:
        begin
          if (hit_a && I_WDATA == D_UNLOCK1)
          begin
            st_d = S_ERS4;
          end
        end
        S_ERS4:
        begin
          if (hit_b && I_WDATA == D_UNLOCK2)
          begin
            st_d = S_ERS5;
          end
        end
        S_ERS5:
        begin
          if (I_WDATA == D_SECT && !par_mode)
          begin
            start_sect = 1'b1;
            st_d       = S_BUSY;
          end
          else if (hit_a && I_WDATA == D_CHIP)
          begin
            start_chip = 1'b1;
            st_d       = S_BUSY;
          end
        end
        S_PROT_CONF:
        begin
          if (I_ADDR == PROT_ADDR && I_WDATA == D_PROT_CONF)
          begin
            start_prot = 1'b1;
            st_d       = S_BUSY;
          end
        end
        default:
        begin
          st_d = S_IDLE;
        end
      endcase
    end
  end

  // operation timer request
  assign tmr_if.start  = start_prog | start_sect | start_chip | start_prot;
  always_comb
  begin
    tmr_if.cycles = TMR_W'(PROG_CYCLES);
    if (start_sect)
    begin
      tmr_if.cycles = TMR_W'(SECT_CYC);
    end
    else if (start_chip)
    begin
      tmr_if.cycles = TMR_W'(CHIP_CYC);
    end
    else if (start_prot)
    begin
      tmr_if.cycles = TMR_W'(PROT_CYCLES);
    end
  end

  // sequencer state and busy flag
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      st_q   <= S_IDLE;
      O_BUSY <= 1'b0;
    end
    else if (I_CE)
    begin
      st_q   <= st_d;
      O_BUSY <= (st_d == S_BUSY);
    end
  end

  // identification mode flag
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      id_q <= 1'b0;
    end
    else if (I_CE)
    begin
      if (id_set)
      begin
        id_q <= 1'b1;
      end
      else if (id_clr)
      begin
        id_q <= 1'b0;
      end
    end
  end

  // array start pulses with latched address, data and sector
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_ARR_PROG             <= 1'b0;
      O_ARR_SECT_ERASE       <= 1'b0;
      O_ARR_CHIP_ERASE       <= 1'b0;
      O_ARR_PROT_SET         <= 1'b0;
      O_ARR_ADDR             <= 16'h0000;
      O_ARR_WDATA            <= 8'h00;
      O_ERASE_SECTOR_ADDRESS <= 4'h0;
    end
    else if (I_CE)
    begin
      O_ARR_PROG       <= start_prog;
      O_ARR_SECT_ERASE <= start_sect;
      O_ARR_CHIP_ERASE <= start_chip;
      O_ARR_PROT_SET   <= start_prot;
      if (start_prog)
      begin
        O_ARR_ADDR  <= I_ADDR;
        O_ARR_WDATA <= I_WDATA;
      end
      if (start_sect)
      begin
        O_ERASE_SECTOR_ADDRESS <= I_ADDR[SECT_MSB:SECT_LSB];
      end
    end
  end

  // toggle bit: primed to one on start, flips on each busy read
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      toggle_q <= 1'b1;
    end
    else if (I_CE)
    begin
      if (tmr_if.start)
      begin
        toggle_q <= 1'b1;
      end
      else if (I_RD && st_q == S_BUSY)
      begin
        toggle_q <= ~toggle_q;
      end
    end
  end

  // read data selection
  always_comb
  begin
    rd_val = I_ARR_RDATA;
    if (par_mode && I_ARR_PROT)
    begin
      rd_val = D_BLOCKED;
    end
    else if (st_q == S_BUSY)
    begin
      rd_val[TOGGLE_BIT] = toggle_q;
    end
    else if (id_q)
    begin
      case (I_ADDR)
        ID_VENDOR_ADDR: rd_val = VENDOR_CODE;
        ID_MACRO_ADDR:  rd_val = MACRO_CODE;
        ID_SIZE_ADDR:   rd_val = SIZE_CODE;
        PROT_ADDR:      rd_val = I_ARR_PROT ? D_PROT_CONF : D_PROT_OFF;
        default:        rd_val = I_ARR_RDATA;
      endcase
    end
  end

  // registered read answer and status outputs
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_RDATA         <= 8'h00;
      O_RVALID        <= 1'b0;
      O_ID_MODE       <= 1'b0;
      O_CMD_EN        <= CMD_EN_RST;
      O_PAR_RD_BLOCK  <= 1'b0;
      O_SER_CMD_BLOCK <= 1'b0;
    end
    else if (I_CE)
    begin
      O_RVALID        <= I_RD;
      O_ID_MODE       <= id_q;
      O_CMD_EN        <= cmd_en_q;
      O_PAR_RD_BLOCK  <= I_ARR_PROT && par_mode;
      O_SER_CMD_BLOCK <= I_ARR_PROT && (mode_q == MODE_SERIAL);
      if (I_RD)
      begin
        O_RDATA <= rd_val;
      end
    end
  end

endmodule

// *** verification/fcs_asserts.sv ***
// Purpose: port checks of the flash command sequencer
// Assumes: one clock, async active-low reset, boot mode held steady
// Notes:   busy length and toggle history live in helper logic
module fcs_asserts
  import fcs_pkg::*;
#(
  parameter int unsigned SECT_CYC    = 50,
  parameter int unsigned CHIP_CYC    = 50,
  parameter logic [7:0]  VENDOR_CODE = 8'h5a
)
(
  input wire logic        I_SYS_CLK,
  input wire logic        I_NRST,
  input wire logic        I_CE,
  input wire logic        I_RD,
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0]  I_WDATA,
  input wire logic        I_CMD_EN_WR,
  input wire logic [3:0]  I_CMD_EN_VAL,
  input wire logic [1:0]  I_BOOT_MODE,
  input wire logic [7:0]  O_RDATA,
  input wire logic        O_RVALID,
  input wire logic        O_BUSY,
  input wire logic        O_ID_MODE,
  input wire logic [3:0]  O_CMD_EN,
  input wire logic        O_ARR_PROG,
  input wire logic        O_ARR_SECT_ERASE,
  input wire logic        O_ARR_CHIP_ERASE,
  input wire logic        O_ARR_PROT_SET,
  input wire logic [15:0] O_ARR_ADDR,
  input wire logic [7:0]  O_ARR_WDATA,
  input wire logic [3:0]  O_ERASE_SECTOR_ADDRESS,
  input wire logic        O_PAR_RD_BLOCK
);
  logic        start;
  logic [31:0] cnt_q;
  logic [31:0] exp_q;
  logic        rdb_q;
  logic        seen_q;
  logic        prev6_q;
  // any operation start pulse
  assign start = O_ARR_PROG | O_ARR_SECT_ERASE | O_ARR_CHIP_ERASE | O_ARR_PROT_SET;
  // busy cycle count and the length expected for the running kind
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    if (!I_NRST)
    begin
      cnt_q <= '0;
      exp_q <= '0;
    end
    else if (I_CE)
    begin
      if (start)
        cnt_q <= 32'h1;
      else if (O_BUSY)
        cnt_q <= cnt_q + 32'h1;
      if (start)
        exp_q <= O_ARR_SECT_ERASE ? SECT_CYC : (O_ARR_CHIP_ERASE ? CHIP_CYC :
          (O_ARR_PROT_SET ? PROT_CYCLES : PROG_CYCLES));
    end
  // toggle history of reads taken while busy
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
    if (!I_NRST)
    begin
      rdb_q   <= 1'b0;
      seen_q  <= 1'b0;
      prev6_q <= 1'b0;
    end
    else
    begin
      rdb_q <= I_CE & I_RD & O_BUSY;
      if (start)
        seen_q <= 1'b0;
      else if (O_RVALID && rdb_q)
        seen_q <= 1'b1;
      if (O_RVALID && rdb_q)
        prev6_q <= O_RDATA[TOGGLE_BIT];
    end
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);
  sequence s_rd;
    I_CE && I_RD;
  endsequence
  sequence s_busy_rd;
    O_RVALID && rdb_q;
  endsequence
  rd_answer_a: assert property (s_rd |=> O_RVALID)
    else $error("read not answered");
  toggle_first_a: assert property ((s_busy_rd and !seen_q) |-> O_RDATA[TOGGLE_BIT])
    else $error("first busy read bit six low");
  toggle_flip_a: assert property ((s_busy_rd and seen_q) |->
    O_RDATA[TOGGLE_BIT] != prev6_q)
    else $error("busy read bit six not inverted");
  busy_len_a: assert property ($fell(O_BUSY) |-> cnt_q == exp_q)
    else $error("busy length wrong");
  no_restart_a: assert property (start |-> !$past(O_BUSY) && O_BUSY)
    else $error("operation started while busy");
  prog_target_a: assert property (O_ARR_PROG |->
    O_ARR_ADDR == $past(I_ADDR) && O_ARR_WDATA == $past(I_WDATA))
    else $error("program target wrong");
  sect_select_a: assert property (O_ARR_SECT_ERASE |-> O_ERASE_SECTOR_ADDRESS ==
    $past(I_ADDR[15:12]) && $past(I_BOOT_MODE, 3) != MODE_PARALLEL)
    else $error("sector erase selection wrong");
  cmd_en_load_a: assert property (I_CE && I_CMD_EN_WR |->
    ##2 O_CMD_EN == $past(I_CMD_EN_VAL, 2))
    else $error("command enable not loaded");
  id_vendor_a: assert property (s_rd ##0 (O_ID_MODE && !O_BUSY &&
    I_ADDR == ID_VENDOR_ADDR) |=> O_RDATA == VENDOR_CODE)
    else $error("vendor code wrong");
  par_block_a: assert property (s_rd ##0 O_PAR_RD_BLOCK |=> O_RDATA == D_BLOCKED)
    else $error("parallel read not blocked");
endmodule

bind fcs_top fcs_asserts #(.SECT_CYC(SECT_CYC), .CHIP_CYC(CHIP_CYC),
  .VENDOR_CODE(VENDOR_CODE)) u_fcs_asserts (.*);

// *** verification/fcs_array_model.sv ***
// Purpose: behavioural flash array behind the sequencer
// Assumes: start pulses are one cycle wide
// Notes:   contents and protection survive reset, as nonvolatile cells do
module fcs_array_model
  import fcs_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_prog,
  input  wire logic        i_sect,
  input  wire logic        i_chip,
  input  wire logic        i_prot_set,
  input  wire logic [15:0] i_waddr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [3:0]  i_sector,
  output logic      [7:0]  o_rdata,
  output logic             o_prot
);
  logic [7:0] mem [0:65535];
  // erased array, protection off
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    o_prot = 1'b0;
  end
  assign o_rdata = mem[i_addr];
  // program, erase and protect actions; nonblocking so the sequencer sees old values
  always @(posedge i_clk)
  begin
    if (i_prog) mem[i_waddr] <= i_wdata;
    if (i_sect) for (int i = 0; i < 4096; i++) mem[{i_sector, 12'(i)}] <= 8'hff;
    if (i_chip) foreach (mem[i]) mem[i] <= 8'hff;
    if (i_chip) o_prot <= 1'b0;
    if (i_prot_set) o_prot <= 1'b1;
  end
endmodule

// *** verification/tb.sv ***
// Purpose: self-checking bench of the flash command sequencer
// Assumes: 100 MHz clock, erase counts shortened to 50 cycles
// Notes:   command addresses carry random upper nibbles
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fcs_pkg::*;
  localparam logic [7:0] VEND = 8'h5a; // arbitrary value
  localparam logic [7:0] MACR = 8'h3c; // arbitrary value
  logic        I_SYS_CLK, I_NRST, I_CE, I_WR, I_RD, I_CMD_EN_WR, I_ARR_PROT;
  logic        O_RVALID, O_BUSY, O_ID_MODE, O_ARR_PROG, O_ARR_SECT_ERASE;
  logic        O_ARR_CHIP_ERASE, O_ARR_PROT_SET, O_PAR_RD_BLOCK, O_SER_CMD_BLOCK;
  logic [15:0] I_ADDR, O_ARR_ADDR, a;
  logic [7:0]  I_WDATA, I_ARR_RDATA, O_RDATA, O_ARR_WDATA, d, r;
  logic [3:0]  I_CMD_EN_VAL, O_CMD_EN, O_ERASE_SECTOR_ADDRESS;
  logic [1:0]  I_BOOT_MODE;
  int          n_mismatch, tests_run, seed;
  fcs_top #(.SECT_CYC(50), .CHIP_CYC(50), .VENDOR_CODE(VEND), .MACRO_CODE(MACR))
    u_fcs_top (.*);
  fcs_array_model u_fcs_array_model (.i_clk(I_SYS_CLK), .i_addr(I_ADDR),
    .i_prog(O_ARR_PROG), .i_sect(O_ARR_SECT_ERASE), .i_chip(O_ARR_CHIP_ERASE),
    .i_prot_set(O_ARR_PROT_SET), .i_waddr(O_ARR_ADDR), .i_wdata(O_ARR_WDATA),
    .i_sector(O_ERASE_SECTOR_ADDRESS), .o_rdata(I_ARR_RDATA), .o_prot(I_ARR_PROT));
  // free-running clock
  initial
  begin
    I_SYS_CLK = 1'b0;
    forever #5 I_SYS_CLK = ~I_SYS_CLK;
  end
  task automatic step();
    @(posedge I_SYS_CLK);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // array byte as seen while busy: the toggle value replaces bit six
  function automatic logic [7:0] busy_exp(input logic [7:0] arr, input logic t);
    busy_exp = arr;
    busy_exp[TOGGLE_BIT] = t;
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one bus write, then an idle cycle
  task automatic wr(input logic [15:0] ad, input logic [7:0] dt);
    I_WR = 1'b1;
    I_ADDR = ad;
    I_WDATA = dt;
    step();
    I_WR = 1'b0;
    step();
  endtask
  task automatic cw(input logic [11:0] lo, input logic [7:0] dt);
    wr({4'($random(seed)), lo}, dt);
  endtask
  task automatic unl();
    cw(CMD_ADDR_A, D_UNLOCK1);
    cw(CMD_ADDR_B, D_UNLOCK2);
  endtask
  task automatic rd(input logic [15:0] ad, output logic [7:0] dt);
    I_RD = 1'b1;
    I_ADDR = ad;
    step();
    I_RD = 1'b0;
    dt = O_RDATA;
    step();
  endtask
  task automatic prog(input logic [15:0] ad, input logic [7:0] dt);
    unl();
    cw(CMD_ADDR_A, D_PROG);
    wr(ad, dt);
  endtask
  task automatic ers(input logic [15:0] ad, input logic [7:0] dt);
    unl();
    cw(CMD_ADDR_A, D_ERASE);
    unl();
    wr(ad, dt);
  endtask
  // poll one address until two reads agree
  task automatic poll(input logic [15:0] ad);
    logic [7:0] x, y;
    for (int i = 0; i < 3000; i++)
    begin
      rd(ad, x);
      rd(ad, y);
      if (x === y) break;
    end
    chk("busy after poll", O_BUSY, 0);
  endtask
  task automatic idrd(input logic [7:0] pv);
    logic [15:0] ia [4];
    logic [7:0]  iv [4];
    ia = '{ID_VENDOR_ADDR, ID_MACRO_ADDR, ID_SIZE_ADDR, PROT_ADDR};
    iv = '{VEND, MACR, SIZE_16K, pv};
    unl();
    cw(CMD_ADDR_A, D_ID_ENTRY);
    chk("id mode", O_ID_MODE, 1);
    foreach (ia[i])
    begin
      rd(ia[i], r);
      chk("id read", r, iv[i]);
    end
  endtask
  task automatic mode(input logic [1:0] m);
    I_BOOT_MODE = m;
    repeat (5) step();
  endtask
  // hang guard
  initial
  begin
    #400000;
    n_mismatch++;
    finish_test();
  end
  // main sequence
  initial
  begin
    seed = 32'hcc2f1391;
    {I_NRST, I_WR, I_RD, I_CMD_EN_WR, I_ADDR, I_WDATA, I_CMD_EN_VAL} = '0;
    I_CE = 1'b1;
    I_BOOT_MODE = MODE_MCU;
    repeat (10) @(posedge I_SYS_CLK);
    #1;
    I_NRST = 1'b1;
    chk("cmd enable reset", O_CMD_EN, CMD_EN_RST);
    a = {2'b11, 14'($random(seed))};
    d = 8'($random(seed));
    prog(a, d);
    chk("busy while disabled", O_BUSY, 0);
    I_CMD_EN_WR = 1'b1;
    I_CMD_EN_VAL = CMD_EN_ON;
    step();
    I_CMD_EN_WR = 1'b0;
    repeat (2) step();
    chk("cmd enable", O_CMD_EN, CMD_EN_ON);
    $display("test enable done");
    prog(a, d);
    chk("busy program", O_BUSY, 1);
    rd(a, r);
    chk("first toggle", r[6], 1);
    chk("busy data", r, busy_exp(d, 1'b1));
    rd(a, r);
    chk("second toggle", r, busy_exp(d, 1'b0));
    prog(a ^ 16'h1, ~d);
    poll(a);
    rd(a, r);
    chk("programmed", r, d);
    rd(a ^ 16'h1, r);
    chk("ignored while busy", r, 8'hff);
    $display("test program done");
    unl();
    cw(CMD_ADDR_A, 8'h77);
    cw(CMD_ADDR_A, D_PROG);
    wr(a ^ 16'h2, 8'h00);
    chk("broken sequence", O_BUSY, 0);
    ers({a[15:12], 12'($random(seed))}, D_SECT);
    chk("sector", O_ERASE_SECTOR_ADDRESS, a[15:12]);
    // clock enable low freezes the running erase well past its length
    I_CE = 1'b0;
    repeat (100) step();
    chk("frozen busy", O_BUSY, 1);
    I_CE = 1'b1;
    poll(a);
    rd(a, r);
    chk("sector erased", r, 8'hff);
    $display("test sector erase done");
    prog(a, d);
    poll(a);
    ers({4'($random(seed)), CMD_ADDR_A}, D_CHIP);
    poll(a);
    rd(a, r);
    chk("chip erased", r, 8'hff);
    idrd(D_PROT_OFF);
    wr(a, D_ID_EXIT);
    chk("id exit single", O_ID_MODE, 0);
    $display("test erase and id done");
    unl();
    cw(CMD_ADDR_A, D_PROT);
    wr(PROT_ADDR, D_PROT_CONF);
    poll(a);
    idrd(D_BLOCKED);
    unl();
    cw(CMD_ADDR_A, D_ID_EXIT);
    chk("id exit three", O_ID_MODE, 0);
    mode(MODE_PARALLEL);
    chk("parallel block", O_PAR_RD_BLOCK, 1);
    rd(a, r);
    chk("parallel read", r, D_BLOCKED);
    ers(a, D_SECT);
    chk("parallel sector erase", O_BUSY, 0);
    mode(MODE_SERIAL);
    chk("serial block", O_SER_CMD_BLOCK, 1);
    mode(MODE_MCU);
    ers({4'($random(seed)), CMD_ADDR_A}, D_CHIP);
    poll(a);
    idrd(D_PROT_OFF);
    wr(a, D_ID_EXIT);
    $display("test protection done");
    finish_test();
  end
endmodule
